// >>> pkg/ffps_pkg.sv
// package: constants and carrier types for the flyback fault-protection sequencer
package ffps_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS     = 4;
  localparam int unsigned UV_BLANK_TIME_MS  = 20;
  localparam int unsigned UV_BLANK_CYCLES   = (UV_BLANK_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned UV_HITS_TO_TRIP   = 4;
  localparam int unsigned SYNC_STAGES       = 2;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic        GATE_EN_RESET     = 1'b0;
  localparam logic        STARTUP_GEN_RESET = 1'b1;
  localparam logic        CC_MODE_RESET     = 1'b1;

  // analog flags, raw from the comparators and supply monitors
  typedef struct packed {
    logic demag_end;     // pulse-level flag: demagnetization just ended
    logic aux_uv_low;    // aux winding sense at or below undervoltage_threshold
    logic sense_oc;      // sense resistor above overcurrent_threshold
    logic switch_cycle;  // one switching cycle began
    logic thermal_hot;   // die above thermal_trip_point (hysteresis in analog)
    logic vdd_on;        // supply at or above supply_turn_on_level
    logic vdd_above_uvlo;// supply above supply_lockout_level
    logic vdd_above_rst; // supply above restart level
  } ffps_flags_t;

  // sequencer outputs toward the power stage
  typedef struct packed {
    logic gate_en;
    logic startup_gen_on;
    logic cc_mode;
  } ffps_drive_t;

  // status toward the rest of the controller
  typedef struct packed {
    logic uv_fault;
    logic oc_warn;
    logic oc_fault;
    logic thermal_fault;
    logic blanking;
  } ffps_status_t;

endpackage : ffps_pkg

// >>> verif/ffps_power_stage.sv
// behavioural power stage: supply node, switching events and comparator flags
`timescale 1ns/1ns
module ffps_power_stage
  import ffps_pkg::*;
#(
  parameter int VDD_ON   = 90,
  parameter int VDD_UVLO = 60,
  parameter int VDD_RST  = 30
) (
  input wire logic                 clk,
  input wire ffps_pkg::ffps_drive_t drive,
  input wire logic                 uv_low,
  input wire logic                 oc,
  input wire logic                 hot,
  output ffps_pkg::ffps_flags_t     flags
);
  int vdd   = 0;
  int phase = 0;

  // supply: aux winding holds it while switching, generator charges, else it decays
  always @(posedge clk) begin
    if (drive.gate_en) vdd <= 100;
    else if (drive.startup_gen_on) vdd <= (vdd < 100) ? vdd + 1 : vdd;
    else vdd <= (vdd > 0) ? vdd - 1 : 0;
    phase <= drive.gate_en ? (phase + 1) % 8 : 0;
  end

  // events only while switching; two-cycle pulses survive the synchroniser
  assign flags = {drive.gate_en && (phase == 4 || phase == 5), uv_low, oc,
                  drive.gate_en && (phase < 2), hot, vdd >= VDD_ON, vdd > VDD_UVLO,
                  vdd > VDD_RST};
endmodule : ffps_power_stage

// >>> verif/ffps_top_assertions.sv
// checker: port-level properties of the fault-protection sequencer
`timescale 1ns/1ns
module ffps_top_assertions
  import ffps_pkg::*;
(
  input wire logic                  CORE_CLK,
  input wire logic                  RST_N,
  input wire ffps_pkg::ffps_flags_t  FLAGS,
  input wire ffps_pkg::ffps_drive_t  DRIVE,
  input wire ffps_pkg::ffps_status_t STATUS
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  // ---------------------------------------------------------------
  // stop and qualification properties
  // ---------------------------------------------------------------
  property p_uv_stop; STATUS.uv_fault |-> !DRIVE.gate_en; endproperty
  a_uv_stop: assert property (p_uv_stop) else $error("gate on during undervoltage fault");
  property p_uv_same; $rose(STATUS.uv_fault) |-> $fell(DRIVE.gate_en); endproperty
  a_uv_same: assert property (p_uv_same) else $error("undervoltage stop late");
  property p_oc_stop; $rose(STATUS.oc_fault) |-> $fell(DRIVE.gate_en); endproperty
  a_oc_stop: assert property (p_oc_stop) else $error("overcurrent stop late");
  // generator must be off soon after an overcurrent stop
  property p_oc_gen; $rose(STATUS.oc_fault) |-> ##[0:2] !DRIVE.startup_gen_on; endproperty
  a_oc_gen: assert property (p_oc_gen) else $error("generator on in oc stop");
  property p_ot_stop; STATUS.thermal_fault |-> !DRIVE.gate_en; endproperty
  a_ot_stop: assert property (p_ot_stop) else $error("gate on while hot");
  property p_ot_trip; FLAGS.thermal_hot [*8] |-> STATUS.thermal_fault; endproperty
  a_ot_trip: assert property (p_ot_trip) else $error("thermal fault missed");
  property p_blank_cc; STATUS.blanking |-> DRIVE.cc_mode; endproperty
  a_blank_cc: assert property (p_blank_cc) else $error("no cc mode in blanking");
  property p_blank_uv; STATUS.blanking |-> !$rose(STATUS.uv_fault); endproperty
  a_blank_uv: assert property (p_blank_uv) else $error("uv fault in blanking");
  property p_warn_run; $rose(STATUS.oc_warn) |-> DRIVE.gate_en; endproperty
  a_warn_run: assert property (p_warn_run) else $error("warning stopped switching");
  // a raw flag cannot act in the very next cycle: it passes the synchroniser first
  property p_sync; $rose(FLAGS.thermal_hot) && DRIVE.gate_en |=> DRIVE.gate_en; endproperty
  a_sync: assert property (p_sync) else $error("flag used unsynchronised");
  c_uv: cover property ($rose(STATUS.uv_fault));
  c_oc: cover property ($rose(STATUS.oc_fault));
  c_ot: cover property ($rose(STATUS.thermal_fault));
endmodule : ffps_top_assertions

bind ffps_top ffps_top_assertions u_ffps_top_assertions (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
  .FLAGS(FLAGS), .DRIVE(DRIVE), .STATUS(STATUS));

// >>> verif/ffps_top_tb_top.sv
// self-checking bench for the fault-protection sequencer
`timescale 1ns/1ns
module ffps_top_tb_top;
  import ffps_pkg::*;
  localparam int BLANK = 50;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         uv_low = 1'b0;
  logic         oc = 1'b0;
  logic         hot = 1'b0;
  time          low_at = 0;
  time          mark = 0;
  logic [7:0]   pat;
  int           seed = 32'h358a751e;
  int           miscompares = 0;
  int           compares = 0;
  ffps_flags_t  flags;
  ffps_drive_t  drive;
  ffps_status_t status;

  always #2 clk = ~clk;
  // last time the supply sat below restart level; compared against a mark taken by the bench
  always @(posedge clk) if (flags.vdd_above_rst === 1'b0) low_at <= $time;

  ffps_power_stage u_ffps_power_stage (.clk(clk), .drive(drive), .uv_low(uv_low), .oc(oc),
    .hot(hot), .flags(flags));
  ffps_top #(.BLANK_CYCLES(BLANK)) u_ffps_top (.CORE_CLK(clk), .RST_N(rst_n), .FLAGS(flags),
    .DRIVE(drive), .STATUS(status));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) begin @(posedge clk); #1; end
  endtask : cyc
  // bounded wait: a stuck gate enable shows as a mismatch, not a hang
  task automatic wait_gate(input logic v);
    int n = 0;
    while (drive.gate_en !== v && n < 2000) begin cyc(1); n++; end
    check(drive.gate_en, v);
  endtask : wait_gate
  task automatic demag_step(input logic v);
    @(negedge flags.demag_end); #1; uv_low = v;
  endtask : demag_step
  // index of the hit completing four in a row, 8 if none
  function automatic int trip_at(input logic [7:0] p);
    int h = 0;
    for (int i = 0; i < 8; i++) begin
      h = p[i] ? h + 1 : 0;
      if (h == 4) return i;
    end
    return 8;
  endfunction : trip_at
  task automatic uv_pattern(input logic [7:0] p);
    int t = trip_at(p);
    demag_step(1'b0);
    for (int i = 0; i <= t && i < 8; i++) demag_step(p[i]);
    if (t < 8) begin
      cyc(16); check({status.uv_fault, drive.gate_en}, 2'b10);
    end else begin
      demag_step(1'b0); cyc(8); check(status.uv_fault, 1'b0);
    end
  endtask : uv_pattern
  // overcurrent trip confined to one switching cycle
  task automatic oc_burst();
    @(negedge flags.switch_cycle); #1; oc = 1'b1; cyc(4); oc = 1'b0;
  endtask : oc_burst
  task automatic tally_and_finish();
    if (miscompares == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin #160000; miscompares++; tally_and_finish(); end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    cyc(12); check({drive, status}, 8'h60); rst_n = 1'b1;
    wait_gate(1'b1); check({status.blanking, drive.cc_mode}, 2'b11);
    uv_low = 1'b1; cyc(20); check(status.uv_fault, 1'b0); uv_low = 1'b0;
    cyc(BLANK); uv_pattern(8'h77);
    for (int k = 0; k < 12 && status.uv_fault !== 1'b1; k++) begin
      pat = 8'($random(seed)); uv_pattern(pat);
    end
    if (status.uv_fault !== 1'b1) uv_pattern(8'h0F);
    uv_low = 1'b0; mark = $time; wait_gate(1'b1);
    check({(low_at > mark), status.blanking, drive.cc_mode}, 3'b111);
    cyc(BLANK + 5); oc_burst(); cyc(3);
    check({status.oc_warn, drive.gate_en}, 2'b11);
    cyc(24); check({status.oc_warn, status.oc_fault}, 2'b00);
    // second burst must land in the switching cycle right after the warning
    oc_burst(); oc_burst(); cyc(4);
    check({status.oc_fault, drive.gate_en, drive.startup_gen_on}, 3'b100);
    mark = $time; wait_gate(1'b1); check((low_at > mark), 1'b1);
    cyc(BLANK + 5); hot = 1'b1; mark = $time; cyc(8);
    check({status.thermal_fault, drive.gate_en}, 2'b10);
    cyc(300); check({(low_at > mark), drive.gate_en}, 2'b10);
    hot = 1'b0; wait_gate(1'b1);
    tally_and_finish();
  end
endmodule : ffps_top_tb_top

// >>> verilog/ffps_sync.sv
// two-flop synchroniser bank for the analog flags
`timescale 1ns/1ns
module ffps_sync #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // stage1 feeds only sync_out; nothing else may look at it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : ffps_sync

// >>> verilog/ffps_top.sv
// flyback fault-protection sequencer: undervoltage, overcurrent and thermal hiccup control
`timescale 1ns/1ns

module ffps_top #(
  parameter int unsigned BLANK_CYCLES = ffps_pkg::UV_BLANK_CYCLES,
  parameter int unsigned UV_HITS      = ffps_pkg::UV_HITS_TO_TRIP
) (
  input  wire logic                   CORE_CLK,
  input  wire logic                   RST_N,
  input  wire ffps_pkg::ffps_flags_t  FLAGS,
  output ffps_pkg::ffps_drive_t       DRIVE,
  output ffps_pkg::ffps_status_t      STATUS
);
  import ffps_pkg::*;

  // ---------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SEQ_WAIT_ON,   // supply charging toward turn-on, generator on
    SEQ_RUN,       // switching
    SEQ_DISCHARGE, // stopped, generator off, waiting for restart level
    SEQ_HOT        // thermal stop, supply recycled
  } ffps_seq_t;

  typedef enum logic [1:0] {
    OC_IDLE,
    OC_WARN,
    OC_TRIP
  } ffps_oc_t;

  localparam int unsigned BW = $clog2(BLANK_CYCLES + 1);
  localparam int unsigned HW = $clog2(UV_HITS + 1);

  // ---------------------------------------------------------------
  // flag synchronisation
  // ---------------------------------------------------------------
  ffps_flags_t flags_s;

  ffps_sync #(
    .WIDTH ($bits(ffps_flags_t))
  ) u_sync (
    .clk      (CORE_CLK),
    .rst_n    (RST_N),
    .async_in (FLAGS),
    .sync_out (flags_s)
  );

  // edge detection on the synchronised strobes
  logic demag_d;
  logic cyc_d;
  logic vdd_on_d;
  wire  demag_evt = flags_s.demag_end & ~demag_d;
  wire  cyc_evt   = flags_s.switch_cycle & ~cyc_d;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      demag_d  <= 1'b0;
      cyc_d    <= 1'b0;
      vdd_on_d <= 1'b0;
    end else begin
      demag_d  <= flags_s.demag_end;
      cyc_d    <= flags_s.switch_cycle;
      vdd_on_d <= flags_s.vdd_on;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  ffps_seq_t         seq;
  ffps_seq_t         next_seq;
  ffps_oc_t          oc;
  ffps_oc_t          next_oc;
  logic [BW-1:0]     blank_cnt;
  logic [BW-1:0]     next_blank_cnt;
  logic [HW-1:0]     uv_cnt;
  logic [HW-1:0]     next_uv_cnt;
  logic              uv_fault;
  logic              hot_recycle;
  logic              next_hot_recycle;
  ffps_drive_t       next_drive;
  ffps_status_t      next_status;

  // ---------------------------------------------------------------
  // undervoltage qualification
  // ---------------------------------------------------------------
  wire running    = (seq == SEQ_RUN);
  wire blanking   = running && (blank_cnt != '0);
  wire uv_sample  = running && !blanking && demag_evt;
  wire uv_hit     = uv_sample && flags_s.aux_uv_low;
  wire uv_qualify = uv_hit && (uv_cnt == HW'(UV_HITS - 1));

  // a sample without a hit restarts the count; a hit adds one
  assign next_uv_cnt = !running || blanking ? '0 :
                       uv_sample && !flags_s.aux_uv_low ? '0 :
                       uv_qualify ? '0 :
                       uv_hit ? uv_cnt + HW'(1) : uv_cnt;

  // blanking reloads on every entry to run, so restarts blank too
  assign next_blank_cnt = (next_seq == SEQ_RUN && seq != SEQ_RUN) ? BW'(BLANK_CYCLES) :
                          (blank_cnt != '0) ? blank_cnt - BW'(1) : blank_cnt;

  // ---------------------------------------------------------------
  // overcurrent two-strike logic
  // ---------------------------------------------------------------
  // a trip is counted per switching cycle; the warning looks at the next one only
  wire oc_trip_now = running && flags_s.sense_oc;
  logic oc_seen;       // set once the switching cycle after the warning has begun
  logic next_oc_seen;

  always_comb begin
    next_oc      = oc;
    next_oc_seen = oc_seen;
    unique case (oc)
      OC_IDLE: begin
        next_oc_seen = 1'b0;
        if (oc_trip_now) begin
          next_oc = OC_WARN;
        end
      end
      OC_WARN: begin
        if (cyc_evt) begin
          next_oc_seen = 1'b1;  // now inside the following cycle
        end else if (oc_seen && oc_trip_now) begin
          next_oc = OC_TRIP;
        end
        if (cyc_evt && oc_seen) begin
          next_oc      = OC_IDLE;
          next_oc_seen = 1'b0;
        end
      end
      OC_TRIP: begin
        next_oc_seen = 1'b0;
        if (seq == SEQ_DISCHARGE && !flags_s.vdd_above_rst) begin
          next_oc = OC_IDLE;
        end
      end
    endcase
    if (!running && oc != OC_TRIP) begin
      next_oc      = OC_IDLE;
      next_oc_seen = 1'b0;
    end
  end

  wire oc_qualify = (oc == OC_WARN) && (next_oc == OC_TRIP);

  // ---------------------------------------------------------------
  // supply and switching sequencer
  // ---------------------------------------------------------------
  wire turn_on_rise = flags_s.vdd_on && !vdd_on_d;
  wire stop_now     = uv_qualify || oc_qualify || flags_s.thermal_hot;

  always_comb begin
    next_seq         = seq;
    next_hot_recycle = hot_recycle;
    unique case (seq)
      SEQ_WAIT_ON: begin
        if (flags_s.thermal_hot) begin
          next_seq = SEQ_HOT;
        end else if (turn_on_rise || flags_s.vdd_on) begin
          next_seq = SEQ_RUN;
        end
      end
      SEQ_RUN: begin
        if (flags_s.thermal_hot) begin
          next_seq = SEQ_HOT;
        end else if (uv_qualify || oc_qualify) begin
          next_seq = SEQ_DISCHARGE;
        end else if (!flags_s.vdd_above_uvlo) begin
          next_seq = SEQ_DISCHARGE;
        end
      end
      SEQ_DISCHARGE: begin
        if (!flags_s.vdd_above_rst) begin
          next_seq = SEQ_WAIT_ON;
        end
      end
      SEQ_HOT: begin
        // generator toggles between restart and turn-on to keep supply alive
        if (!flags_s.vdd_above_rst) begin
          next_hot_recycle = 1'b1;
        end else if (flags_s.vdd_on) begin
          next_hot_recycle = 1'b0;
        end
        if (!flags_s.thermal_hot) begin
          next_hot_recycle = 1'b0;
          if (flags_s.vdd_above_uvlo) begin
            next_seq = SEQ_RUN;
          end else begin
            next_seq = SEQ_DISCHARGE;
          end
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // output decode
  // ---------------------------------------------------------------
  // gate drops combinationally on the qualifying cycle, then registered
  assign next_drive.gate_en        = (next_seq == SEQ_RUN) && !stop_now;
  assign next_drive.startup_gen_on = (next_seq == SEQ_WAIT_ON) ||
                                     (next_seq == SEQ_HOT && next_hot_recycle);
  // constant-current mode holds through the whole blanking window of each start
  assign next_drive.cc_mode        = (next_seq != SEQ_RUN) ||
                                     (next_blank_cnt != '0);
  assign next_status.uv_fault      = uv_qualify || (uv_fault && next_seq != SEQ_WAIT_ON);
  assign next_status.oc_warn       = (next_oc == OC_WARN);
  assign next_status.oc_fault      = (next_oc == OC_TRIP);
  assign next_status.thermal_fault = (next_seq == SEQ_HOT);
  assign next_status.blanking      = (next_blank_cnt != '0) && (next_seq == SEQ_RUN);

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      seq         <= SEQ_WAIT_ON;
      oc          <= OC_IDLE;
      oc_seen     <= 1'b0;
      blank_cnt   <= '0;
      uv_cnt      <= '0;
      hot_recycle <= 1'b0;
    end else begin
      seq         <= next_seq;
      oc          <= next_oc;
      oc_seen     <= next_oc_seen;
      blank_cnt   <= next_blank_cnt;
      uv_cnt      <= next_uv_cnt;
      hot_recycle <= next_hot_recycle;
    end
  end

  // outputs straight from flip-flops
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      DRIVE    <= '{gate_en: GATE_EN_RESET, startup_gen_on: STARTUP_GEN_RESET,
                    cc_mode: CC_MODE_RESET};
      STATUS   <= '0;
      uv_fault <= 1'b0;
    end else begin
      DRIVE    <= next_drive;
      STATUS   <= next_status;
      uv_fault <= next_status.uv_fault;
    end
  end

endmodule : ffps_top
